// ### hw/cpu_exec.sv
/*
 Execute slice for watchdog clear, call, complement, clears and decrements.
 Assumes a same-clock fetch stage that presents one word per cycle and a
 register file whose read data is combinational on the given address.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_exec
    import exec_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic                 instr_valid,
    input  wire logic [INSTR_W-1:0]   instr,
    output logic                      instr_ready,
    output logic                      flush,
    output logic [PC_W-1:0]           program_counter,
    output logic [FADDR_W-1:0]        file_raddr,
    input  wire logic [7:0]           file_rdata,
    output logic                      file_we,
    output logic [FADDR_W-1:0]        file_waddr,
    output logic [7:0]                file_wdata,
    output logic                      stack_push,
    output logic [PC_W-1:0]           stack_top_entry,
    input  wire logic                 sleep_enter,
    output logic                      zero_flag,
    output logic                      timeout_flag,
    output logic                      powerdown_flag,
    output logic [7:0]                working_reg,
    input  wire logic [2:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata
);

    // Shared arithmetic
    function automatic logic [7:0] dec8(input logic [7:0] v);
        dec8 = v - 8'h01;
    endfunction : dec8

    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction : is_zero

    // State and storage
    exec_state_e         state_q;
    exec_state_e         state_d;
    logic [PC_W-1:0]     pc_q;
    logic [PC_W-1:0]     pc_d;
    logic [7:0]          work_q;
    logic [7:0]          page_q;
    logic                zero_q;
    logic                to_q;
    logic                pd_q;
    logic                fwe_q;
    logic [FADDR_W-1:0]  fwaddr_q;
    logic [7:0]          fwdata_q;
    logic                push_q;
    logic [PC_W-1:0]     tos_q;
    logic [7:0]          rdata_q;
    logic                flush_call_q;

    wdog_if wd ();

    wdog_counter u_wdog (
        .clock (clock),
        .nrst  (nrst),
        .wd    (wd)
    );

    // Field extraction
    wire [5:0]          opcode = instr[OP_HI:OP_LO];
    wire [FADDR_W-1:0]  faddr  = instr[FADDR_W-1:0];
    wire                dsel   = instr[DSEL_BIT];
    wire [IMM_W-1:0]    imm    = instr[IMM_W-1:0];

    // Instruction taken this cycle
    wire running = (state_q == ST_RUN);
    wire take    = instr_valid && running;

    // Decode of the covered instructions
    wire is_wdclr = (instr == WORD_WDCLR);
    wire is_call  = (instr[OP_HI:IMM_W] == OP_CALL);
    wire is_comp  = (opcode == OP_COMPL);
    wire is_decr  = (opcode == OP_DECR);
    wire is_dskip = (opcode == OP_DECSKIP);
    wire is_fclr  = (opcode == OP_CLEAR) && dsel;
    wire is_wclr  = (opcode == OP_CLEAR) && !dsel;

    // Instructions that honour the destination selector
    wire dest_op  = is_comp || is_decr || is_dskip;

    // Operand with forwarding of the pending file write
    wire fwd_hit = fwe_q && (fwaddr_q == faddr);
    wire [7:0] operand = fwd_hit ? fwdata_q : file_rdata;

    // Result selection
    wire [7:0] dec_res = dec8(operand);
    wire [7:0] cmp_res = ~operand;
    wire [7:0] result  = is_comp ? cmp_res
                       : (is_decr || is_dskip) ? dec_res
                       : 8'h00;

    wire to_file = take && ((dest_op && dsel) || is_fclr);
    wire to_work = take && ((dest_op && !dsel) || is_wclr);

    wire skip = take && is_dskip && is_zero(dec_res);
    wire two_cycle = (take && is_call) || skip;

    // call target from page latch and immediate
    wire [PC_W-1:0] call_target = {page_q[PAGE_HI:PAGE_LO], imm};
    // return address is pc plus one
    wire [PC_W-1:0] ret_addr = pc_q + 13'h0001;

    // Zero flag sources; call and decrement-skip never touch it
    // call leaves status
    wire zero_upd = take && (is_comp || is_decr || is_fclr || is_wclr);
    wire zero_val = is_zero(result);

    // Register port decode
    wire wr_status = reg_wr && (reg_addr == ADDR_STATUS);
    wire wr_work   = reg_wr && (reg_addr == ADDR_WORK);
    wire wr_page   = reg_wr && (reg_addr == ADDR_PAGE);

    // Read mux, unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            ADDR_STATUS:
            begin
                rd_mux[ZERO_BIT] = zero_q;
                rd_mux[PD_BIT]   = pd_q;
                rd_mux[TO_BIT]   = to_q;
            end
            ADDR_WORK:  rd_mux = work_q;
            ADDR_PAGE:  rd_mux = page_q;
            ADDR_PC_LO: rd_mux = pc_q[7:0];
            ADDR_PC_HI: rd_mux = {3'b000, pc_q[PC_W-1:8]};
            ADDR_WDOG:  rd_mux = wd.count;
            default:    rd_mux = 8'h00;
        endcase
    end

    // Held next values and one-cycle sources for the clocked blocks
    // call starts its hold
    wire               call_take  = take && is_call;
    wire               wdclr_take = take && is_wdclr;
    wire               hold_step  = (state_q == ST_HOLD) && !flush_call_q;
    wire [PC_W-1:0]    tos_d      = call_take ? ret_addr : tos_q;
    wire [FADDR_W-1:0] fwaddr_d   = to_file ? faddr : fwaddr_q;
    wire [7:0]         fwdata_d   = to_file ? result : fwdata_q;

    // Next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            // single cycle unless call or skip
            ST_RUN:  state_d = two_cycle ? ST_HOLD : ST_RUN;
            ST_HOLD: state_d = ST_RUN;
            default: state_d = ST_RUN;
        endcase
    end

    // Next program counter
    always_comb
    begin
        pc_d = pc_q;
        if (take)
        begin
            pc_d = is_call ? call_target : ret_addr;
        end
        else if (hold_step)
        begin
            pc_d = pc_q + 13'h0001;
        end
    end

    // Remembers whether the hold cycle belongs to a call
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            flush_call_q <= 1'b0;
        else
            flush_call_q <= call_take;
    end

    // State and program counter
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_RUN;
            pc_q    <= PC_RST;
        end
        else
        begin
            state_q <= state_d;
            pc_q    <= pc_d;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            push_q <= 1'b0;
            tos_q  <= PC_RST;
        end
        else
        begin
            push_q <= call_take;
            tos_q  <= tos_d;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            fwe_q    <= 1'b0;
            fwaddr_q <= {FADDR_W{1'b0}};
            fwdata_q <= 8'h00;
        end
        else
        begin
            fwe_q    <= to_file;
            fwaddr_q <= fwaddr_d;
            fwdata_q <= fwdata_d;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            work_q <= WORK_RST;
        else if (to_work)
            work_q <= result;
        else if (wr_work)
            work_q <= reg_wdata;
    end

    // Page latch, software only
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            page_q <= PAGE_RST;
        else if (wr_page)
            page_q <= reg_wdata;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            zero_q <= ZERO_RST;
        else if (zero_upd)
            zero_q <= zero_val;
        else if (wr_status)
            zero_q <= reg_wdata[ZERO_BIT];
    end

    // timeout and powerdown flags, set wins
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            to_q <= FLAG_RST;
            pd_q <= FLAG_RST;
        end
        else if (wdclr_take)
        begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end
        else
        begin
            to_q <= wd.expire ? 1'b0 : to_q;
            pd_q <= sleep_enter ? 1'b0 : pd_q;
        end
    end

    assign wd.clear = wdclr_take;

    // Registered read data
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rdata_q <= 8'h00;
        else if (reg_rd)
            rdata_q <= rd_mux;
        else
            rdata_q <= 8'h00;
    end

    // Handshake toward fetch
    assign instr_ready = running;
    assign flush       = (state_q == ST_HOLD);

    // Program counter and register file ports
    assign program_counter = pc_q;
    assign file_raddr      = faddr;
    assign file_we         = fwe_q;
    assign file_waddr      = fwaddr_q;
    assign file_wdata      = fwdata_q;

    // Return stack push
    assign stack_push      = push_q;
    assign stack_top_entry = tos_q;

    // Status flags
    assign zero_flag       = zero_q;
    assign timeout_flag    = to_q;
    assign powerdown_flag  = pd_q;

    // Working register and software read data
    assign working_reg     = work_q;
    assign reg_rdata       = rdata_q;

endmodule : cpu_exec
`default_nettype wire

// ### hw/exec_pkg.sv
/*
 Constants, encodings and state type for the instruction execute slice.
 Assumes one instruction cycle per clock at 250 MHz and a same-clock fetch stage.
*/
//
// Function
// - Watchdog clear zeroes the watchdog counter and its prescaler.
// - Watchdog clear sets timeout and powerdown flags, no other status bits.
// - Call pushes program counter plus one as new stack top entry.
// - Call loads immediate into PC 10:0, page latch bits 4:3 into PC 12:11.
// - Call immediate spans 0 to 2047; call changes no status flag.
// - Call takes two instruction cycles.
// - File operands take a 7-bit address and a one-bit destination selector.
// - Selector 0 writes working register, 1 writes the addressed file register.
// - Complement inverts the register and updates only the zero flag.
// - Register clear writes zero to the file register and sets zero flag.
// - Working clear writes zero to working register and sets zero flag.
// - Decrement subtracts one modulo 256, writes destination, updates zero flag.
// - Decrement-skip subtracts one, writes destination, changes no status flag.
// - Zero decrement-skip result discards next instruction, runs a no-op, two cycles.
package exec_pkg;

    // Instruction word layout
    localparam int INSTR_W  = 14;
    localparam int PC_W     = 13;
    localparam int IMM_W    = 11;
    localparam int FADDR_W  = 7;
    localparam int DSEL_BIT = 7;
    localparam int OP_HI    = 13;
    localparam int OP_LO    = 8;
    localparam int PAGE_HI  = 4;
    localparam int PAGE_LO  = 3;

    // Opcode encodings
    localparam logic [5:0]  OP_CLEAR   = 6'h01;
    localparam logic [5:0]  OP_DECR    = 6'h03;
    localparam logic [5:0]  OP_COMPL   = 6'h09;
    localparam logic [5:0]  OP_DECSKIP = 6'h0B;
    localparam logic [2:0]  OP_CALL    = 3'h4;
    localparam logic [13:0] WORD_WDCLR = 14'h0064;

    // Register port map
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_WORK   = 3'h1;
    localparam logic [2:0] ADDR_PAGE   = 3'h2;
    localparam logic [2:0] ADDR_PC_LO  = 3'h3;
    localparam logic [2:0] ADDR_PC_HI  = 3'h4;
    localparam logic [2:0] ADDR_WDOG   = 3'h5;

    // Status bit positions
    localparam int ZERO_BIT = 2;
    localparam int PD_BIT   = 3;
    localparam int TO_BIT   = 4;

    // Values after reset
    localparam logic [7:0]  WORK_RST = 8'h00;
    localparam logic [7:0]  PAGE_RST = 8'h00;
    localparam logic [12:0] PC_RST   = 13'h0000;
    localparam logic [7:0]  WDOG_RST = 8'h00;
    localparam logic        ZERO_RST = 1'b0;
    localparam logic        FLAG_RST = 1'b1;

    // Cycle counts
    localparam int CYC_SINGLE = 1;
    localparam int CYC_DOUBLE = 2;

    // Execute states, one-hot
    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_HOLD = 2'b10
    } exec_state_e;

endpackage : exec_pkg

// ### hw/wdog_if.sv
/*
 Carrier between the execute slice and its watchdog counter.
 Assumes both ends share the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface wdog_if;
    logic       clear;
    logic       expire;
    logic [7:0] count;

    modport core (output clear, input expire, input count);
    modport dog  (input clear, output expire, output count);
endinterface : wdog_if
`default_nettype wire

// ### hw/wdog_counter.sv
/*
 Watchdog counter with an 8-bit prescaler ahead of it.
 Assumes a clear pulse one cycle long from the execute slice.
*/
`timescale 1ns/1ps
`default_nettype none
module wdog_counter
    import exec_pkg::*;
(
    input  wire logic clock,
    input  wire logic nrst,
    wdog_if.dog       wd
);

    logic [7:0] presc_q;
    logic [7:0] count_q;
    logic       expire_q;
    wire        presc_wrap = (presc_q == 8'hFF);
    wire        count_wrap = (count_q == 8'hFF);

    // Prescaler and counter, cleared together
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            presc_q  <= WDOG_RST;
            count_q  <= WDOG_RST;
            expire_q <= 1'b0;
        end
        else if (wd.clear)
        begin
            presc_q  <= WDOG_RST;
            count_q  <= WDOG_RST;
            expire_q <= 1'b0;
        end
        else
        begin
            presc_q  <= presc_q + 8'h01;
            count_q  <= presc_wrap ? count_q + 8'h01 : count_q;
            expire_q <= presc_wrap && count_wrap;
        end
    end

    assign wd.count  = count_q;
    assign wd.expire = expire_q;

endmodule : wdog_counter
`default_nettype wire

// ### test/exec_asserts.sv
/*
 Port-level checker for the execute slice.
 Assumes binding onto cpu_exec and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module exec_asserts
    import exec_pkg::*;
(
    input wire logic                clock,
    input wire logic                nrst,
    input wire logic                instr_valid,
    input wire logic [INSTR_W-1:0]  instr,
    input wire logic                instr_ready,
    input wire logic                flush,
    input wire logic [PC_W-1:0]     program_counter,
    input wire logic [7:0]          file_rdata,
    input wire logic                file_we,
    input wire logic [FADDR_W-1:0]  file_waddr,
    input wire logic [7:0]          file_wdata,
    input wire logic                stack_push,
    input wire logic [PC_W-1:0]     stack_top_entry,
    input wire logic                zero_flag,
    input wire logic                timeout_flag,
    input wire logic                powerdown_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // Taken word and its opcode field
    logic       take;
    logic [5:0] op;
    assign take = instr_valid && instr_ready;
    assign op   = instr[OP_HI:OP_LO];

    // Operand as the slice sees it, pending file write forwarded
    logic [7:0] opnd;
    assign opnd = (file_we && file_waddr == instr[FADDR_W-1:0]) ? file_wdata : file_rdata;

    // Effects of each taken word
    call_push_a:
        assert property (take && op[5:3] == OP_CALL |=> stack_push && stack_top_entry == $past(program_counter) + 13'h0001)
        else $error("call return address wrong");
    call_target_a:
        assert property (take && op[5:3] == OP_CALL |=> program_counter[10:0] == $past(instr[10:0]))
        else $error("call target wrong");
    call_hold_a:
        assert property (take && op[5:3] == OP_CALL |=> flush && !instr_ready ##1 instr_ready)
        else $error("call length wrong");
    wdog_flags_a:
        assert property (take && instr == WORD_WDCLR |=> timeout_flag && powerdown_flag)
        else $error("watchdog clear flags wrong");
    compl_zero_a:
        assert property (take && op == OP_COMPL |=> zero_flag == ($past(opnd) == 8'hff))
        else $error("complement zero flag wrong");
    decr_file_a:
        assert property (take && op == OP_DECR && instr[DSEL_BIT] |=> file_we && file_waddr == $past(instr[6:0])
                         && file_wdata == $past(opnd) - 8'h01)
        else $error("decrement write wrong");
    skip_flags_a:
        assert property (take && op == OP_DECSKIP |=> $stable(zero_flag))
        else $error("skip changed zero flag");
    skip_hold_a:
        assert property (take && op == OP_DECSKIP && opnd == 8'h01 |=> flush && !instr_ready ##1 instr_ready)
        else $error("skip length wrong");
    clear_zero_a:
        assert property (take && op == OP_CLEAR |=> zero_flag)
        else $error("clear zero flag wrong");
endmodule : exec_asserts
`default_nettype wire

// ### test/tb.sv
/*
 Self-checking bench for the execute slice.
 Assumes the package and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
    import exec_pkg::*;
    ;
    logic                clock, nrst, instr_valid, sleep_enter, reg_wr, reg_rd, instr_ready, flush;
    logic                file_we, stack_push, zero_flag, timeout_flag, powerdown_flag;
    logic [INSTR_W-1:0]  instr;
    logic [7:0]          file_rdata, reg_wdata, working_reg, reg_rdata, file_wdata, d;
    logic [2:0]          reg_addr;
    logic [PC_W-1:0]     program_counter, stack_top_entry, pc0;
    logic [FADDR_W-1:0]  file_raddr, file_waddr;
    int                  mismatches, checks_done, cycles = 0;

    cpu_exec cpu_exec_inst (.clock(clock), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .flush(flush), .program_counter(program_counter), .file_raddr(file_raddr),
        .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
        .stack_push(stack_push), .stack_top_entry(stack_top_entry), .sleep_enter(sleep_enter),
        .zero_flag(zero_flag), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
        .working_reg(working_reg), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // Clock, 4 ns period
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : bus

    task automatic run(input logic [13:0] w, input logic [7:0] v);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr <= w;
        file_rdata <= v;
        #1 pc0 = program_counter;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
    endtask : run

    task automatic t_wdog();
        bus(1'b0, 3'h7, 8'h00);
        chk(d, 8'h00);
        @(posedge clock);
        sleep_enter <= 1'b1;
        @(posedge clock);
        sleep_enter <= 1'b0;
        // Past one watchdog expiry, with a nonzero count again
        repeat (66000) @(posedge clock);
        chk({timeout_flag, powerdown_flag}, 2'b00);
        run(WORD_WDCLR, 8'h00);
        chk({timeout_flag, powerdown_flag}, 2'b11);
        bus(1'b0, ADDR_WDOG, 8'h00);
        chk(d, 8'h00);
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk(d, 8'h18);
    endtask : t_wdog

    task automatic t_call();
        logic [7:0]  pg [2] = '{8'h18, 8'h08};
        logic [10:0] k [2]  = '{11'h7ff, 11'h000};
        for (int i = 0; i < 2; i++)
        begin
            bus(1'b1, ADDR_PAGE, pg[i]);
            run({OP_CALL, k[i]}, 8'h00);
            chk(program_counter, {pg[i][4:3], k[i]});
            chk({stack_push, stack_top_entry}, {1'b1, pc0 + 13'h0001});
            chk({flush, instr_ready, zero_flag}, 3'b100);
        end
    endtask : t_call

    task automatic t_file();
        logic [5:0] op [3]  = '{OP_COMPL, OP_DECR, OP_DECR};
        logic [7:0] src [3] = '{8'hff, 8'h00, 8'h01};
        logic [7:0] res [3] = '{8'h00, 8'hff, 8'h00};
        logic [6:0] f;
        for (int i = 0; i < 6; i++)
        begin
            f = i[0] ? 7'h7f : 7'h00;
            run({op[i/2], i[0], f}, src[i/2]);
            chk(file_raddr, f);
            if (i[0])
                chk({file_we, file_waddr, file_wdata}, {1'b1, f, res[i/2]});
            else
                chk({file_we, working_reg}, {1'b0, res[i/2]});
            chk(zero_flag, res[i/2] == 8'h00);
        end
    endtask : t_file

    task automatic t_clear();
        run({OP_DECR, 1'b0, 7'h05}, 8'h05);
        run({OP_CLEAR, 1'b1, 7'h2a}, 8'h33);
        chk({file_we, file_waddr, file_wdata, zero_flag}, {1'b1, 7'h2a, 8'h00, 1'b1});
        run({OP_DECR, 1'b0, 7'h05}, 8'h05);
        run(14'h0100, 8'h77);
        chk({zero_flag, working_reg}, {1'b1, 8'h00});
    endtask : t_clear

    task automatic t_skip();
        run({OP_DECR, 1'b0, 7'h05}, 8'h05);
        run({OP_DECSKIP, 1'b0, 7'h11}, 8'h01);
        chk({flush, instr_ready, working_reg, zero_flag}, {2'b10, 8'h00, 1'b0});
        @(posedge clock);
        #1 chk({instr_ready, program_counter}, {1'b1, pc0 + 13'h0002});
        run({OP_DECSKIP, 1'b1, 7'h11}, 8'h05);
        chk({flush, instr_ready, file_we, file_wdata, zero_flag}, {3'b011, 8'h04, 1'b0});
        chk(program_counter, pc0 + 13'h0001);
    endtask : t_skip

    task automatic conclude();
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // Main sequence
    initial
    begin
        {nrst, instr_valid, sleep_enter, reg_wr, reg_rd} = '0;
        instr = '0;
        file_rdata = '0;
        reg_addr = '0;
        reg_wdata = '0;
        mismatches = 0;
        checks_done = 0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk(d, 8'h18);
        t_wdog();
        t_call();
        t_file();
        t_clear();
        t_skip();
        conclude();
    end
endmodule : tb

bind cpu_exec exec_asserts exec_asserts_inst (.clock(clock), .nrst(nrst), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .flush(flush), .program_counter(program_counter),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .stack_push(stack_push), .stack_top_entry(stack_top_entry), .zero_flag(zero_flag),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
`default_nettype wire
